// [mcd_top.sv]
// Audio master clock divider: APB registers, enable sequencing,
// on-the-fly ratio update, pin direction and interrupt status.
// Assumes one clock pclk; input clocks and the pin arrive synchronous.
//
// How it works
// - Bit 31 of control shows update pending
// - Ratio changes ignored while update pending
// - Enable bit runs divider, drives pin out
// - Enable clear: pin is input, bypasses divider
// - Enable reads one until divider fully stopped
// - Bits 25:24 pick input clock zero..three
// - Input select frozen while divider enabled
// - Divide write while running starts update
// - Divide writes dropped while update pending
// - Divide write while stopped loads directly, no flag
// - Output equals input times (frac+1)/(div+1)
// - Reserved bits read zero, writes ignored
// - Both input edges used, no new edges
`default_nettype none

module mcd_top
    import mcd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  div_clk_in,
    input  wire logic        mclk_i,
    output logic             mclk_o,
    output logic             mclk_oe,
    output logic             mclk_int,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    mcd_state_e  state_q;
    mcd_ratio_s  ratio_q;
    mcd_ratio_s  active_q;
    mcd_ratio_s  wr_ratio;
    logic        pend_q;
    logic [1:0]  sync_cnt_q;
    logic [1:0]  sel_q;
    logic [1:0]  stat_q;
    logic [1:0]  stat_d;
    logic [1:0]  mask_q;
    logic [1:0]  stat_clr;
    logic [31:0] rdata_d;
    logic        err_d;
    logic        take;
    logic        wr_mcr;
    logic        wr_mdr;
    logic        wr_mask;
    logic        rd_stat;
    logic        edge_p;
    logic        div_out;
    logic        upd_done;
    logic        stop_done;
    logic        running;

    assign running = (state_q != MCD_OFF);

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, then the transfer is taken
    assign take    = psel & penable & pready;
    assign wr_mcr  = take & pwrite & (paddr == MCD_MCR_OFF);
    assign wr_mdr  = take & pwrite & (paddr == MCD_MDR_OFF);
    assign wr_mask = take & pwrite & (paddr == MCD_MASK_OFF);
    assign rd_stat = take & ~pwrite & (paddr == MCD_STAT_OFF);

    assign wr_ratio.frac = pwdata[MDR_FRAC_MSB:MDR_FRAC_LSB];
    assign wr_ratio.div  = pwdata[MDR_DIV_MSB:MDR_DIV_LSB];

    always_comb begin
        rdata_d = 32'h0;
        err_d   = 1'b0;
        case (paddr)
            MCD_MCR_OFF: begin
                rdata_d[MCR_PEND_BIT] = pend_q;
                rdata_d[MCR_MOE_BIT]  = running;
                rdata_d[MCR_SEL_MSB:MCR_SEL_LSB] = sel_q;
            end
            MCD_MDR_OFF: begin
                rdata_d[MDR_FRAC_MSB:MDR_DIV_LSB] = ratio_q;
            end
            MCD_STAT_OFF: begin
                rdata_d[STAT_STOP_BIT:STAT_UPD_BIT] = stat_q;
            end
            MCD_MASK_OFF: begin
                rdata_d[STAT_STOP_BIT:STAT_UPD_BIT] = mask_q;
            end
            default: begin
                err_d = 1'b1;
            end
        endcase
    end

    // Read data is captured in the wait cycle and held for the taken edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & err_d;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0 : rdata_d;
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable sequencing
    // A cleared enable waits for a low output, so no runt pulse leaves.
    // Never stop on an input edge: the core would still toggle on it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MCD_OFF;
        end else begin
            case (state_q)
                MCD_OFF: begin
                    if (wr_mcr && pwdata[MCR_MOE_BIT]) begin
                        state_q <= MCD_RUN;
                    end
                end
                MCD_RUN: begin
                    if (wr_mcr && !pwdata[MCR_MOE_BIT]) begin
                        state_q <= MCD_STOP;
                    end
                end
                MCD_STOP: begin
                    if (wr_mcr && pwdata[MCR_MOE_BIT]) begin
                        state_q <= MCD_RUN;
                    end else if (!div_out && !edge_p) begin
                        state_q <= MCD_OFF;
                    end
                end
                default: begin
                    state_q <= MCD_OFF;
                end
            endcase
        end
    end

    assign stop_done = (state_q == MCD_STOP) && !div_out && !edge_p &&
                       !(wr_mcr && pwdata[MCR_MOE_BIT]);

    // Changing the source under a running divider would glitch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= MCD_SEL_RST;
        end else if (wr_mcr && !running) begin
            sel_q <= pwdata[MCR_SEL_MSB:MCR_SEL_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ratio and on-the-fly update
    assign upd_done = pend_q &&
                      (!running || (edge_p && sync_cnt_q == MCD_SYNC_LAST));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_q    <= MCD_RATIO_RST;
            active_q   <= MCD_RATIO_RST;
            pend_q     <= 1'b0;
            sync_cnt_q <= 2'h0;
        end else if (pend_q) begin
            // Writes arriving now are dropped
            if (upd_done) begin
                active_q <= ratio_q;
                pend_q   <= 1'b0;
            end else if (edge_p) begin
                sync_cnt_q <= sync_cnt_q + 2'h1;
            end
        end else if (wr_mdr) begin
            ratio_q <= wr_ratio;
            if (running) begin
                pend_q     <= 1'b1;
                sync_cnt_q <= 2'h0;
            end else begin
                active_q <= wr_ratio;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divider datapath
    mcd_edge_sel u_edge (
        .clk    (pclk),
        .rst_n  (presetn),
        .clk_in (div_clk_in),
        .sel    (sel_q),
        .edge_p (edge_p)
    );

    mcd_frac_core u_core (
        .clk     (pclk),
        .rst_n   (presetn),
        .run     (running),
        .edge_p  (edge_p),
        .ratio   (active_q),
        .clk_out (div_out)
    );

    // Pin direction follows the enable; the disabled pin is a bypass input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_oe  <= 1'b0;
            mclk_o   <= 1'b0;
            mclk_int <= 1'b0;
        end else begin
            mclk_oe  <= running;
            mclk_o   <= div_out;
            mclk_int <= mclk_oe ? div_out : mclk_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: only bits seen by the read are cleared, and a new
    // event in the clearing cycle survives
    assign stat_clr = rd_stat ? prdata[STAT_STOP_BIT:STAT_UPD_BIT] : 2'h0;

    always_comb begin
        stat_d = stat_q & ~stat_clr;
        stat_d[STAT_UPD_BIT]  = stat_d[STAT_UPD_BIT] | upd_done;
        stat_d[STAT_STOP_BIT] = stat_d[STAT_STOP_BIT] | stop_done;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= MCD_EVT_RST;
            irq    <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq    <= |(stat_d & mask_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MCD_EVT_RST;
        end else if (wr_mask) begin
            mask_q <= pwdata[STAT_STOP_BIT:STAT_UPD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_fly_write;
        wr_mdr && running && !pend_q;
    endsequence

    sequence s_sync_end;
        pend_q && running && edge_p && sync_cnt_q == MCD_SYNC_LAST;
    endsequence

    sequence s_stop_req;
        wr_mcr && !pwdata[MCR_MOE_BIT] && state_q == MCD_RUN;
    endsequence

    pend_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_fly_write |=> pend_q && ratio_q == $past(wr_ratio)
                        && active_q == $past(active_q))
        else $error("update flag not raised by running divide write");

    upd_block_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pend_q && wr_mdr |=> $stable(ratio_q))
        else $error("divide write accepted while update pending");

    mdr_drop_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pend_q && wr_mdr && !upd_done |=> pend_q && $stable(active_q))
        else $error("pending update disturbed by divide write");

    off_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_mdr && !running && !pend_q |=>
            !pend_q && active_q == $past(wr_ratio))
        else $error("stopped divide write not loaded directly");

    sync_done_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_sync_end |=> !pend_q && active_q == ratio_q ##1 stat_q[0])
        else $error("update flag not cleared after synchronisation");

    sel_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        running |=> $stable(sel_q))
        else $error("input select changed while divider enabled");

    out_dir_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == MCD_RUN |=> mclk_oe ##1 mclk_o == $past(div_out))
        else $error("pin not driven from divider while enabled");

    bypass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !mclk_oe |=> mclk_int == $past(mclk_i))
        else $error("input pin not bypassing divider");

    moe_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_stop_req ##1 (div_out && !wr_mcr) |=> state_q == MCD_STOP)
        else $error("enable dropped before divider stopped");

    rsvd_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        take && !pwrite && paddr == MCD_MCR_OFF |->
            prdata[29:26] == 4'h0 && prdata[23:0] == 24'h0)
        else $error("reserved control bits read nonzero");

    mdr_rsvd_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        take && !pwrite && paddr == MCD_MDR_OFF |->
            prdata[31:20] == 12'h0)
        else $error("reserved divide bits read nonzero");

    off_quiet_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == MCD_OFF |-> !div_out)
        else $error("divider output high after full stop");

    edge_only_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $changed(div_out) |-> $past(edge_p))
        else $error("divider output edge without input edge");

endmodule

`default_nettype wire

// [mcd_pkg.sv]
// Package for the audio master clock divider: register map, field
// positions, reset values, state encoding and the ratio carrier.
// Assumes a 12-bit APB byte address and 32-bit data words.
`default_nettype none

package mcd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [11:0] MCD_MCR_OFF  = 12'h100;
    localparam logic [11:0] MCD_MDR_OFF  = 12'h104;
    localparam logic [11:0] MCD_STAT_OFF = 12'h108;
    localparam logic [11:0] MCD_MASK_OFF = 12'h10c;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int MCR_PEND_BIT  = 31;
    localparam int MCR_MOE_BIT   = 30;
    localparam int MCR_SEL_LSB   = 24;
    localparam int MCR_SEL_MSB   = 25;
    localparam int MDR_FRAC_LSB  = 12;
    localparam int MDR_FRAC_MSB  = 19;
    localparam int MDR_DIV_LSB   = 0;
    localparam int MDR_DIV_MSB   = 11;
    localparam int STAT_UPD_BIT  = 0;
    localparam int STAT_STOP_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and timing counts
    localparam logic [1:0] MCD_SEL_RST   = 2'h0;
    localparam logic [1:0] MCD_EVT_RST   = 2'h0;
    // Input-clock edges counted before a new ratio is handed to the divider
    localparam logic [1:0] MCD_SYNC_LAST = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [7:0]  frac;
        logic [11:0] div;
    } mcd_ratio_s;

    localparam mcd_ratio_s MCD_RATIO_RST = '0;

    typedef enum logic [1:0] {
        MCD_OFF,
        MCD_RUN,
        MCD_STOP
    } mcd_state_e;

endpackage

`default_nettype wire

// [mcd_edge_sel.sv]
// Edge finder for the four divider input clocks, with source select.
// Assumes the input clocks are sampled as synchronous levels on clk.
`default_nettype none

module mcd_edge_sel
    import mcd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] clk_in,
    input  wire logic [1:0] sel,
    output logic            edge_p
);

    logic [3:0] prev_q;
    logic [3:0] chg;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_src
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev_q[i] <= 1'b0;
                end else begin
                    prev_q[i] <= clk_in[i];
                end
            end
            assign chg[i] = prev_q[i] ^ clk_in[i];
        end
    endgenerate

    // Rising and falling edges both count, so a half period is one step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_p <= 1'b0;
        end else begin
            edge_p <= chg[sel];
        end
    end

endmodule

`default_nettype wire

// [mcd_frac_core.sv]
// Fractional divider core: toggles its output only on input-clock edges.
// Assumes edge_p pulses once per input edge and ratio.frac <= ratio.div.
`default_nettype none

module mcd_frac_core
    import mcd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       edge_p,
    input  wire mcd_ratio_s ratio,
    output logic            clk_out
);

    logic [12:0] acc_q;
    logic [12:0] sum;
    logic [12:0] lim;

    always_comb begin
        sum = acc_q + {5'h0, ratio.frac} + 13'h1;
        lim = {1'b0, ratio.div} + 13'h1;
    end

    // Each input edge adds frac+1; crossing div+1 makes one output edge,
    // so at most one output edge per input edge and none in between
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q   <= 13'h0;
            clk_out <= 1'b0;
        end else if (!run) begin
            acc_q   <= 13'h0;
            clk_out <= 1'b0;
        end else if (edge_p) begin
            if (sum >= lim) begin
                acc_q   <= sum - lim;
                clk_out <= ~clk_out;
            end else begin
                acc_q   <= sum;
            end
        end
    end

endmodule

`default_nettype wire

// [mcd_clk_src.sv]
// Far-side model: four divider source clocks and an external master
// clock that drives the pin only while the block leaves it as input.
// Assumes pclk is the only clock; sources are slow against pclk.
`default_nettype none

module mcd_clk_src
    import mcd_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_out_en,
    output logic [3:0] src_clk,
    output logic       ext_clk,
    output logic       ext_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] cnt_q [4];
    logic [2:0] ecnt_q;

    ////////////////////////////////////////////////////////////////////////
    // Half periods of 3, 4, 5 and 6 cycles, so a wrong select shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_clk <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (cnt_q[i] == 3'(2 + i)) begin
                    cnt_q[i]   <= 3'h0;
                    src_clk[i] <= ~src_clk[i];
                end else begin
                    cnt_q[i] <= cnt_q[i] + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ecnt_q  <= 3'h0;
            ext_clk <= 1'b0;
        end else begin
            ecnt_q <= (ecnt_q == 3'h3) ? 3'h0 : ecnt_q + 3'h1;
            if (ecnt_q == 3'h3) begin
                ext_clk <= ~ext_clk;
            end
        end
    end

    // Never fight the block for the pin
    assign ext_oe = ~pin_out_en;

endmodule

`default_nettype wire

// [mcd_top_tb_top.sv]
// Self-checking bench: registers over APB, enable sequencing, select,
// ratio, on-the-fly update and interrupt.
// Assumes the far-side clock model mcd_clk_src.
`default_nettype none

module mcd_top_tb_top
    import mcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, rd_val;
    logic [3:0]  src_clk;
    logic        pready, pslverr, mclk_o, mclk_oe, mclk_int, irq, err_val;
    logic        ext_clk, ext_oe, mclk_pin, prev;
    int          n_errors   = 0;
    int          num_checks = 0;

    always #5 pclk = ~pclk;
    assign mclk_pin = ext_oe ? ext_clk : mclk_o;

    mcd_top i_mcd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .div_clk_in(src_clk), .mclk_i(mclk_pin), .mclk_o(mclk_o),
        .mclk_oe(mclk_oe), .mclk_int(mclk_int), .irq(irq));

    mcd_clk_src i_mcd_clk_src (.pclk(pclk), .presetn(presetn),
        .pin_out_en(mclk_oe), .src_clk(src_clk), .ext_clk(ext_clk),
        .ext_oe(ext_oe));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_val = prdata;
        err_val = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd_val, exp);
    endtask

    // Bounded poll until a bit reads zero
    task automatic poll(input logic [11:0] a, input int b);
        int n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (rd_val[b] !== 1'b0 && n < 100);
    endtask

    // Edge counts over a window; slack of two output edges
    task automatic ratio(input int sel, input int f, input int d);
        int   e, o;
        logic ps, po;
        e = 0;
        o = 0;
        ps = src_clk[sel];
        po = mclk_o;
        repeat (600) begin
            @(posedge pclk);
            e += int'(src_clk[sel] !== ps);
            o += int'(mclk_o !== po);
            ps = src_clk[sel];
            po = mclk_o;
        end
        check({31'h0, (o * (d + 1) <= e * (f + 1) + 2 * (d + 1)
            && o * (d + 1) + 2 * (d + 1) >= e * (f + 1))}, 32'h1);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Whole run is near 3300 cycles; allow about twelve times that
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(MCD_MCR_OFF, 32'h0);
        rdchk(MCD_MDR_OFF, 32'h0);
        rdchk(MCD_STAT_OFF, 32'h0);
        rdchk(MCD_MASK_OFF, 32'h0);
        apb(1'b0, 12'h200, 32'h0);
        check({31'h0, err_val}, 32'h1);
        check(rd_val, 32'h0);
        apb(1'b1, MCD_MCR_OFF, 32'h3eff_ffff);
        rdchk(MCD_MCR_OFF, 32'h0200_0000);
        apb(1'b1, MCD_MDR_OFF, 32'hfff0_1003);
        rdchk(MCD_MDR_OFF, 32'h0000_1003);
        rdchk(MCD_MCR_OFF, 32'h0200_0000);
        $display("test registers done");
        for (int i = 0; i < 40; i++) begin
            prev = mclk_pin;
            @(posedge pclk);
            check({30'h0, mclk_oe, mclk_int}, {31'h0, prev});
        end
        $display("test bypass done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, MCD_MCR_OFF, 32'h4000_0000 | (32'(k) << 24));
            rdchk(MCD_MCR_OFF, 32'h4000_0000 | (32'(k) << 24));
            apb(1'b1, MCD_MCR_OFF, 32'h4000_0000 | (32'(k ^ 1) << 24));
            rdchk(MCD_MCR_OFF, 32'h4000_0000 | (32'(k) << 24));
            check({31'h0, mclk_oe}, 32'h1);
            check({31'h0, mclk_int}, {31'h0, mclk_pin});
            ratio(k, 1, 3);
            apb(1'b1, MCD_MCR_OFF, 32'h0);
            poll(MCD_MCR_OFF, MCR_MOE_BIT);
            check({31'h0, mclk_o}, 32'h0);
            repeat (2) @(posedge pclk);
            check({31'h0, mclk_oe}, 32'h0);
            rdchk(MCD_STAT_OFF, 32'h2);
        end
        $display("test select done");
        apb(1'b1, MCD_MCR_OFF, 32'h4300_0000);
        apb(1'b1, MCD_MDR_OFF, 32'h0000_0005);
        rdchk(MCD_MCR_OFF, 32'hc300_0000);
        apb(1'b1, MCD_MDR_OFF, 32'h0000_2007);
        poll(MCD_MCR_OFF, MCR_PEND_BIT);
        check(rd_val, 32'h4300_0000);
        rdchk(MCD_MDR_OFF, 32'h0000_0005);
        ratio(3, 0, 5);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, MCD_MASK_OFF, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        rdchk(MCD_STAT_OFF, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rdchk(MCD_STAT_OFF, 32'h0);
        $display("test update done");
        report_and_stop();
    end

endmodule

`default_nettype wire
